// ### core/mpb_map.vh
// Purpose: Register offsets, field positions, reset values and counts for mpb_pins.
// Assumes: 4-bit register address, 8-bit register data.
// Notes: Definitions only.
`ifndef MPB_MAP_VH
`define MPB_MAP_VH

// Register offsets
`define MPB_A_CTRL 4'h0
`define MPB_A_PA_DATA 4'h1
`define MPB_A_PA_DIR 4'h2
`define MPB_A_PB_DATA 4'h3
`define MPB_A_PC_DATA 4'h4
`define MPB_A_PC_DIR 4'h5
`define MPB_A_PC_LATCH 4'h6
`define MPB_A_STATUS 4'h7
`define MPB_A_OC_EN 4'h8

// Control register fields
`define MPB_CTRL_IRQ_EDGE 0
`define MPB_CTRL_STROBE_OUT_B_EN 1
`define MPB_CTRL_HSHK 2
`define MPB_CTRL_STROBE_IN_A_RISE 3
`define MPB_CTRL_STROBE_OUT_B_HIGH 4
`define MPB_CTRL_PA7_OC1 5

// Status register fields
`define MPB_ST_MODE_LO 0
`define MPB_ST_MODE_HI 1
`define MPB_ST_XMASK 2
`define MPB_ST_IRQ_PEND 3
`define MPB_ST_STROBE_IN_A_FLAG 4
`define MPB_ST_HSHK_BUSY 5

// Reset values
`define MPB_CTRL_RST 8'h00
`define MPB_DATA_RST 8'h00
`define MPB_DIR_RST 8'h00
`define MPB_OC_EN_RST 5'h00

// Mode codes {boot_select_high, boot_select_low}
`define MPB_MODE_SINGLE 2'b10
`define MPB_MODE_EXP 2'b11
`define MPB_MODE_BOOT 2'b00
`define MPB_MODE_TEST 2'b01

// Timing counts in oscillator cycles
`define MPB_E_DIV 4
`define MPB_STROBE_OUT_B_CYC 3'h4
`define MPB_RST_DRIVE_CYC 8'h10

`endif

// ### core/mpb_sync.v
// Purpose: Two-flop synchroniser for a vector of pin inputs.
// Assumes: Single clock mclk, clock enable ce, synchronous active-high reset.
// Notes: The first stage feeds only the second.
`default_nettype none

module mpb_sync #(
  parameter W = 8,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire mclk,
  input wire ce,
  input wire rst,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta_reg;

  always @(posedge mclk) begin
    if (rst) begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// ### core/mpb_pins.v
// Purpose: Pin-level logic of an 8-bit controller: modes, bus clock, interrupts, ports A-C.
// Assumes: mclk is the oscillator input; CPU and timer sit on the same clock.
// Notes: Ports D and E are outside this block.
//
// Overview of operation
// - Reset pin initialises the device; driven low open-drain on monitor or watchdog failure.
// - Bus-phase clock output runs at one quarter of the oscillator frequency.
// - Bus-phase clock low means internal processing; high means data access.
// - Bus-phase clock stops toggling in stop mode.
// - Maskable interrupt edge or level selectable; level selected at every reset.
// - Non-maskable input is level sensitive; reset sets its mask until software clears.
// - Mode pins sampled during reset select one of four operating modes.
// - After mode latch, instruction start flag pulls low during opcode fetch cycle.
// - Expanded mode: transfer direction low for writes, high for reads.
// - Transfer direction stays low across back-to-back write cycles.
// - Single-chip: strobe A is edge-detecting input, strobe B programmable strobe output.
// - Expanded mode: address latch pulse output separates low address from data.
// - Ports A, D, E keep their function in every mode.
// - Port A gives three captures, four compares, plus accumulator or fifth compare.
// - Port A pins not used by the timer are general-purpose lines.
// - Single-chip port B is output only; reads return pin-side levels.
// - Simple strobed mode pulses strobe B on each port B write.
// - Expanded mode: address bits 8 to 15 on port B every bus cycle.
// - Single-chip port C general I/O, latched on strobe A edge, full handshake.
// - Expanded mode: port C carries low address, then data while clock high.
// - Expanded mode: address, direction, strobe driven on every cycle, internal ones too.
`include "mpb_map.vh"
`default_nettype none

module mpb_pins (
  input wire mclk,
  input wire ce,
  input wire rst,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire clock_monitor_fail,
  input wire watchdog_fail,
  input wire reset_n_in,
  output reg reset_n_out,
  output reg reset_n_oe,
  output reg core_reset,
  input wire stop_mode,
  input wire [15:0] cpu_bus_addr,
  input wire [7:0] cpu_bus_wdata,
  input wire cpu_bus_wr,
  input wire cpu_opfetch,
  output reg cpu_cycle_start,
  output reg cpu_bus_done,
  output reg [7:0] cpu_bus_rdata,
  output reg e_clock,
  input wire irq_n,
  input wire irq_ack,
  output reg irq_request,
  input wire nonmaskable_interrupt_in,
  input wire xmask_clear,
  output reg nonmaskable_interrupt_in_request,
  input wire boot_select_high,
  input wire boot_select_low,
  output reg [1:0] op_mode,
  output reg instruction_start_flag_out,
  output reg instruction_start_flag_oe,
  input wire strobe_in_a,
  output reg address_latch_pulse,
  output reg address_latch_pulse_oe,
  output reg strobe_out_b,
  input wire [7:0] port_a_in,
  output reg [7:0] port_a_out,
  output reg [7:0] port_a_oe,
  input wire [4:0] timer_oc,
  output reg [2:0] input_capture,
  output reg pulse_accumulator_in,
  input wire [7:0] port_b_in,
  output reg [7:0] port_b_out,
  input wire [7:0] port_c_in,
  output reg [7:0] port_c_out,
  output reg [7:0] port_c_oe
);

  function is_exp;
    input [1:0] m;
    begin
      is_exp = (m == `MPB_MODE_EXP) || (m == `MPB_MODE_TEST);
    end
  endfunction

  // Pin inputs, idle levels high where the pin is pulled up
  wire [27:0] pins_s;
  wire [1:0] boot_s;
  mpb_sync #(.W(28), .RST_VAL(28'h000_000f)) u_sync (
    .mclk(mclk),
    .ce(ce),
    .rst(rst),
    .d({port_c_in, port_b_in, port_a_in, strobe_in_a, nonmaskable_interrupt_in, irq_n, reset_n_in}),
    .q(pins_s)
  );
  // Mode pins never reset, else reset would latch the reset value instead of the pins
  mpb_sync #(.W(2), .RST_VAL(2'b00)) u_mode_sync (
    .mclk(mclk),
    .ce(ce),
    .rst(1'b0),
    .d({boot_select_high, boot_select_low}),
    .q(boot_s)
  );
  wire rstpin_s = pins_s[0];
  wire irq_s = pins_s[1];
  wire nonmaskable_interrupt_in_s = pins_s[2];
  wire strobe_in_a_s = pins_s[3];
  wire [7:0] pa_s = pins_s[11:4];
  wire [7:0] pb_s = pins_s[19:12];
  wire [7:0] pc_s = pins_s[27:20];

  wire crst = rst | ~rstpin_s;

  reg [7:0] ctrl_reg, pa_data_reg, pa_dir_reg, pb_data_reg, pc_data_reg, pc_dir_reg, pc_latch_reg;
  reg [4:0] oc_en_reg;
  reg [1:0] mode_reg;
  reg mode_ok_reg, xmask_reg, irq_pend_reg, irq_prev_reg, strobe_in_a_prev_reg, strobe_in_a_flag_reg, hshk_busy_reg;
  reg [7:0] drive_cnt_reg;
  reg [2:0] strobe_out_b_cnt_reg;
  reg [1:0] ph_reg;
  reg [15:0] cyc_addr_reg;
  reg [7:0] cyc_wdata_reg;
  reg cyc_wr_reg, cyc_fetch_reg, rd_pend_reg, rd_cap_reg;

  wire exp = is_exp(mode_reg);
  wire wr_hit = reg_wr;
  wire rd_status = reg_rd && (reg_addr == `MPB_A_STATUS);
  wire rd_latch = reg_rd && (reg_addr == `MPB_A_PC_LATCH);
  wire wr_pb = wr_hit && (reg_addr == `MPB_A_PB_DATA);

  // Bus-phase clock
  // Stop parks the phase at the end of a cycle so the restart is a whole cycle
  wire [1:0] ph_next = (stop_mode && ph_reg == 2'd3) ? ph_reg : ph_reg + 2'd1;
  wire start = ~stop_mode && (ph_next == 2'd0);
  wire [15:0] cyc_addr_next = start ? cpu_bus_addr : cyc_addr_reg;
  wire [7:0] cyc_wdata_next = start ? cpu_bus_wdata : cyc_wdata_reg;
  wire cyc_wr_next = start ? cpu_bus_wr : cyc_wr_reg;
  wire cyc_fetch_next = start ? cpu_opfetch : cyc_fetch_reg;

  // Strobe A edge, programmable polarity
  wire strobe_in_a_edge = ctrl_reg[`MPB_CTRL_STROBE_IN_A_RISE] ? (strobe_in_a_s & ~strobe_in_a_prev_reg) : (~strobe_in_a_s & strobe_in_a_prev_reg);
  wire irq_fall = irq_prev_reg & ~irq_s;

  always @(posedge mclk) begin
    if (rst) begin
      drive_cnt_reg <= 8'h00;
      reset_n_oe <= 1'b0;
      reset_n_out <= 1'b0;
      core_reset <= 1'b1;
    end else if (ce) begin
      // Counter resets on rst only, so our own pull does not cancel itself
      if (clock_monitor_fail || watchdog_fail)
        drive_cnt_reg <= `MPB_RST_DRIVE_CYC;
      else if (drive_cnt_reg != 8'h00)
        drive_cnt_reg <= drive_cnt_reg - 8'h01;
      reset_n_oe <= clock_monitor_fail | watchdog_fail | (drive_cnt_reg > 8'h01);
      reset_n_out <= 1'b0;
      core_reset <= crst;
    end
  end

  // Mode latch and interrupt state
  always @(posedge mclk) begin
    if (ce) begin
      if (crst) begin
        mode_reg <= boot_s;
        mode_ok_reg <= 1'b0;
        xmask_reg <= 1'b1;
        irq_pend_reg <= 1'b0;
        irq_prev_reg <= 1'b1;
      end else begin
        mode_ok_reg <= 1'b1;
        if (xmask_clear)
          xmask_reg <= 1'b0;
        irq_prev_reg <= irq_s;
        if (irq_fall)
          irq_pend_reg <= 1'b1;
        else if (irq_ack)
          irq_pend_reg <= 1'b0;
      end
    end
  end

  always @(posedge mclk) begin
    if (ce) begin
      if (crst) begin
        irq_request <= 1'b0;
        nonmaskable_interrupt_in_request <= 1'b0;
        op_mode <= `MPB_MODE_SINGLE;
      end else begin
        irq_request <= ctrl_reg[`MPB_CTRL_IRQ_EDGE] ? irq_pend_reg : ~irq_s;
        nonmaskable_interrupt_in_request <= ~nonmaskable_interrupt_in_s & ~xmask_reg;
        op_mode <= mode_reg;
      end
    end
  end

  // Software registers
  always @(posedge mclk) begin
    if (ce) begin
      if (crst) begin
        ctrl_reg <= `MPB_CTRL_RST;
        pa_data_reg <= `MPB_DATA_RST;
        pa_dir_reg <= `MPB_DIR_RST;
        pb_data_reg <= `MPB_DATA_RST;
        pc_data_reg <= `MPB_DATA_RST;
        pc_dir_reg <= `MPB_DIR_RST;
        oc_en_reg <= `MPB_OC_EN_RST;
      end else if (wr_hit) begin
        case (reg_addr)
          `MPB_A_CTRL: ctrl_reg <= reg_wdata;
          `MPB_A_PA_DATA: pa_data_reg <= reg_wdata;
          `MPB_A_PA_DIR: pa_dir_reg <= reg_wdata;
          `MPB_A_PB_DATA: pb_data_reg <= reg_wdata;
          `MPB_A_PC_DATA: pc_data_reg <= reg_wdata;
          `MPB_A_PC_DIR: pc_dir_reg <= reg_wdata;
          `MPB_A_OC_EN: oc_en_reg <= reg_wdata[4:0];
          default: ;
        endcase
      end
    end
  end

  // Port C latch and handshake; a new edge wins over a clearing read
  always @(posedge mclk) begin
    if (ce) begin
      if (crst) begin
        pc_latch_reg <= `MPB_DATA_RST;
        strobe_in_a_prev_reg <= 1'b1;
        strobe_in_a_flag_reg <= 1'b0;
        hshk_busy_reg <= 1'b0;
      end else begin
        strobe_in_a_prev_reg <= strobe_in_a_s;
        if (strobe_in_a_edge && !exp) begin
          pc_latch_reg <= pc_s;
          strobe_in_a_flag_reg <= 1'b1;
          hshk_busy_reg <= ctrl_reg[`MPB_CTRL_HSHK];
        end else begin
          if (rd_status)
            strobe_in_a_flag_reg <= 1'b0;
          if (rd_latch)
            hshk_busy_reg <= 1'b0;
        end
      end
    end
  end

  always @(posedge mclk) begin
    if (ce) begin
      if (crst)
        strobe_out_b_cnt_reg <= 3'h0;
      else if (wr_pb && ctrl_reg[`MPB_CTRL_STROBE_OUT_B_EN] && !exp)
        strobe_out_b_cnt_reg <= `MPB_STROBE_OUT_B_CYC;
      else if (strobe_out_b_cnt_reg != 3'h0)
        strobe_out_b_cnt_reg <= strobe_out_b_cnt_reg - 3'h1;
    end
  end

  // Register read, data in the cycle after the strobe
  always @(posedge mclk) begin
    if (ce) begin
      if (crst)
        reg_rdata <= 8'h00;
      else if (reg_rd) begin
        case (reg_addr)
          `MPB_A_CTRL: reg_rdata <= ctrl_reg;
          `MPB_A_PA_DATA: reg_rdata <= pa_s;
          `MPB_A_PA_DIR: reg_rdata <= pa_dir_reg;
          `MPB_A_PB_DATA: reg_rdata <= pb_s;
          `MPB_A_PC_DATA: reg_rdata <= (pc_s & ~pc_dir_reg) | (pc_data_reg & pc_dir_reg);
          `MPB_A_PC_DIR: reg_rdata <= pc_dir_reg;
          `MPB_A_PC_LATCH: reg_rdata <= pc_latch_reg;
          `MPB_A_STATUS: reg_rdata <= {2'b00, hshk_busy_reg, strobe_in_a_flag_reg, irq_pend_reg, xmask_reg, mode_reg};
          `MPB_A_OC_EN: reg_rdata <= {3'b000, oc_en_reg};
          default: reg_rdata <= 8'h00;
        endcase
      end else
        reg_rdata <= 8'h00;
    end
  end

  // Bus cycle sequencing
  always @(posedge mclk) begin
    if (ce) begin
      if (crst) begin
        ph_reg <= 2'd3;
        cyc_addr_reg <= 16'h0000;
        cyc_wdata_reg <= 8'h00;
        cyc_wr_reg <= 1'b0;
        cyc_fetch_reg <= 1'b0;
        rd_pend_reg <= 1'b0;
        rd_cap_reg <= 1'b0;
      end else begin
        ph_reg <= ph_next;
        cyc_addr_reg <= cyc_addr_next;
        cyc_wdata_reg <= cyc_wdata_next;
        cyc_wr_reg <= cyc_wr_next;
        cyc_fetch_reg <= cyc_fetch_next;
        // Pin data is two stages late; catch it at phase 1 of the next cycle
        if (start) begin
          rd_pend_reg <= ~cyc_wr_reg;
          rd_cap_reg <= 1'b0;
        end else
          rd_cap_reg <= rd_pend_reg && (ph_reg == 2'd0) && !stop_mode;
      end
    end
  end

  always @(posedge mclk) begin
    if (ce) begin
      if (crst) begin
        e_clock <= 1'b0;
        cpu_cycle_start <= 1'b0;
        cpu_bus_done <= 1'b0;
        cpu_bus_rdata <= 8'h00;
        instruction_start_flag_out <= 1'b0;
        instruction_start_flag_oe <= 1'b0;
      end else begin
        e_clock <= ~stop_mode & ph_next[1];
        cpu_cycle_start <= start;
        cpu_bus_done <= rd_cap_reg | (start & cyc_wr_reg);
        if (rd_cap_reg)
          cpu_bus_rdata <= pc_s;
        instruction_start_flag_out <= 1'b0;
        instruction_start_flag_oe <= mode_ok_reg & cyc_fetch_next & ~stop_mode;
      end
    end
  end

  // Strobe pins, port B and port C by mode
  always @(posedge mclk) begin
    if (ce) begin
      if (crst) begin
        address_latch_pulse <= 1'b0;
        address_latch_pulse_oe <= 1'b0;
        strobe_out_b <= 1'b1;
        port_b_out <= 8'h00;
        port_c_out <= 8'h00;
        port_c_oe <= 8'h00;
      end else if (exp) begin
        // Driven on every cycle whether or not the target is outside
        address_latch_pulse_oe <= 1'b1;
        address_latch_pulse <= ~stop_mode & (ph_next == 2'd0);
        strobe_out_b <= ~cyc_wr_next;
        port_b_out <= cyc_addr_next[15:8];
        if (!ph_next[1] || stop_mode) begin
          port_c_out <= cyc_addr_next[7:0];
          port_c_oe <= 8'hff;
        end else begin
          port_c_out <= cyc_wdata_next;
          port_c_oe <= {8{cyc_wr_next}};
        end
      end else begin
        address_latch_pulse <= 1'b0;
        address_latch_pulse_oe <= 1'b0;
        if (ctrl_reg[`MPB_CTRL_HSHK])
          strobe_out_b <= hshk_busy_reg ~^ ctrl_reg[`MPB_CTRL_STROBE_OUT_B_HIGH];
        else
          strobe_out_b <= (strobe_out_b_cnt_reg != 3'h0) ~^ ctrl_reg[`MPB_CTRL_STROBE_OUT_B_HIGH];
        port_b_out <= pb_data_reg;
        port_c_out <= pc_data_reg;
        port_c_oe <= pc_dir_reg;
      end
    end
  end

  // Port A is the same in every mode
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_pa
      wire oc_sel;
      wire oc_val;
      if (i >= 3) begin : g_oc
        assign oc_sel = (i < 7) ? oc_en_reg[7-i] : ctrl_reg[`MPB_CTRL_PA7_OC1];
        assign oc_val = timer_oc[7-i];
      end else begin : g_ic
        assign oc_sel = 1'b0;
        assign oc_val = 1'b0;
      end
      always @(posedge mclk) begin
        if (ce) begin
          if (crst) begin
            port_a_out[i] <= 1'b0;
            port_a_oe[i] <= 1'b0;
          end else if (oc_sel) begin
            port_a_out[i] <= oc_val;
            port_a_oe[i] <= 1'b1;
          end else begin
            port_a_out[i] <= pa_data_reg[i];
            port_a_oe[i] <= pa_dir_reg[i];
          end
        end
      end
    end
  endgenerate

  always @(posedge mclk) begin
    if (ce) begin
      if (crst) begin
        input_capture <= 3'b000;
        pulse_accumulator_in <= 1'b0;
      end else begin
        input_capture <= {pa_s[2], pa_s[1], pa_s[0]};
        pulse_accumulator_in <= pa_s[7] & ~ctrl_reg[`MPB_CTRL_PA7_OC1];
      end
    end
  end

endmodule

`default_nettype wire

// ### sim/mpb_pins_assertions.sv
// Purpose: Pin timing checks for mpb_pins.
// Assumes: One clock, ce held high.
// Notes: Expanded checks key on op_mode bit 0.
`default_nettype none
module mpb_pins_assertions (
  input wire logic mclk,
  input wire logic rst,
  input wire logic stop_mode,
  input wire logic watchdog_fail,
  input wire logic reset_n_oe,
  input wire logic core_reset,
  input wire logic e_clock,
  input wire logic nonmaskable_interrupt_in_request,
  input wire logic [1:0] op_mode,
  input wire logic instruction_start_flag_oe,
  input wire logic address_latch_pulse,
  input wire logic strobe_out_b,
  input wire logic [7:0] port_c_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (core_reset);
  sequence s_e_high;
    e_clock [*2];
  endsequence
  sequence s_e_low;
    !e_clock [*2];
  endsequence
  a_eclk_high_len: assert property (disable iff (core_reset || stop_mode) $rose(e_clock) |-> s_e_high ##1 !e_clock)
    else $error("bus clock high phase not two cycles");
  a_eclk_low_len: assert property (disable iff (core_reset || stop_mode) $fell(e_clock) |-> s_e_low ##1 e_clock)
    else $error("bus clock low phase not two cycles");
  a_eclk_stop_frozen: assert property (stop_mode && $past(stop_mode) && $past(stop_mode, 2) |-> $stable(e_clock))
    else $error("bus clock moved in stop mode");
  a_as_clock_low: assert property (address_latch_pulse |-> !e_clock ##1 !address_latch_pulse)
    else $error("address latch pulse not a short pulse in clock low");
  a_as_every_cycle: assert property ($rose(e_clock) && op_mode[0] |-> $past(address_latch_pulse, 2))
    else $error("bus cycle without address latch pulse");
  a_addr_driven: assert property (address_latch_pulse && op_mode[0] |-> port_c_oe == 8'hff)
    else $error("low address not driven on port C");
  a_data_direction: assert property (e_clock && op_mode[0] |-> port_c_oe == (strobe_out_b ? 8'h00 : 8'hff))
    else $error("port C drive disagrees with direction");
  a_rw_steady_high: assert property (e_clock && op_mode[0] |-> $stable(strobe_out_b))
    else $error("direction changed during data phase");
  a_mode_held: assert property ($past(!core_reset) |-> $stable(op_mode))
    else $error("mode changed outside reset");
  a_xmask_at_reset: assert property (disable iff (rst) $fell(core_reset) |-> !nonmaskable_interrupt_in_request ##1 !nonmaskable_interrupt_in_request)
    else $error("nonmaskable request unmasked after reset");
  a_rst_pin_drive: assert property (disable iff (rst) $fell(watchdog_fail) |-> ##1 reset_n_oe [*8])
    else $error("reset pin not pulled after failure");
  a_fetch_flag: assert property ($rose(instruction_start_flag_oe) |-> (!e_clock && instruction_start_flag_oe)
    ##1 instruction_start_flag_oe [*3])
    else $error("instruction start flag not one bus cycle");
endmodule
bind mpb_pins mpb_pins_assertions u_chk (.*);
`default_nettype wire

// ### sim/mpb_ext_mem.sv
// Purpose: External memory on the muxed bus.
// Assumes: Selected when the high address byte is SEL_HI.
// Notes: Released data lines show the inverse of the last read.
`default_nettype none
module mpb_ext_mem #(parameter logic [7:0] SEL_HI = 8'h12) (
  input wire logic mclk,
  input wire logic e_clock,
  input wire logic address_latch_pulse,
  input wire logic strobe_out_b,
  input wire logic [7:0] port_b_out,
  input wire logic [7:0] pc_pin,
  output logic [7:0] pc_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  logic [7:0] lo;
  logic [7:0] last = 8'h00;
  logic sel;
  logic rd_en;
  wire logic we_n = ~(~strobe_out_b & e_clock);
  always @(negedge address_latch_pulse) lo <= pc_pin;
  assign sel = port_b_out === SEL_HI;
  assign rd_en = sel && e_clock && strobe_out_b;
  assign pc_drv = rd_en ? mem[lo] : ~last;
  always @(posedge mclk) begin
    if (!we_n && sel)
      mem[lo] <= pc_pin;
    if (rd_en)
      last <= mem[lo];
  end
endmodule
`default_nettype wire

// ### sim/mpb_pins_tb.sv
// Purpose: Self-checking bench for mpb_pins.
// Assumes: ce tied high; timer compares idle.
// Notes: Bus checks assume one request per four clocks.
`include "mpb_map.vh"
`default_nettype none
module mpb_pins_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, clock_monitor_fail = 1'b0, watchdog_fail = 1'b0;
  logic stop_mode = 1'b0, cpu_bus_wr = 1'b0, cpu_opfetch = 1'b0, irq_n = 1'b1, irq_ack = 1'b0;
  logic nonmaskable_interrupt_in = 1'b1, xmask_clear = 1'b0, strobe_in_a = 1'b1, pb_ovr = 1'b0;
  logic boot_select_high = 1'b1, boot_select_low = 1'b1, pw = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, cpu_bus_wdata = 8'h00, pc_ext = 8'h00, pc_drv;
  logic [15:0] cpu_bus_addr = 16'h0000, pa = 16'h0000;
  logic [7:0] reg_rdata, cpu_bus_rdata, port_a_out, port_a_oe, port_b_out, port_c_out, port_c_oe;
  logic [7:0] port_a_in, port_b_in, port_c_in;
  logic [2:0] input_capture;
  logic [1:0] op_mode;
  logic reset_n_in, reset_n_out, reset_n_oe, core_reset, cpu_cycle_start, cpu_bus_done, e_clock;
  logic irq_request, nonmaskable_interrupt_in_request, instruction_start_flag_out, instruction_start_flag_oe;
  logic address_latch_pulse, address_latch_pulse_oe, strobe_out_b, pulse_accumulator_in;
  int miscompares = 0, samples_checked = 0;
  // Pull-up on the reset pin; design only ever pulls low
  assign reset_n_in = reset_n_oe ? reset_n_out : 1'b1;
  assign port_a_in = (port_a_oe & port_a_out) | (~port_a_oe & 8'h05);
  // Pin-side level may differ from the latch when a load fights it
  assign port_b_in = pb_ovr ? 8'hc3 : port_b_out;
  assign port_c_in = (port_c_oe & port_c_out) | (~port_c_oe & (op_mode[0] ? pc_drv : pc_ext));
  mpb_pins dut (.*, .ce(1'b1), .timer_oc(5'h00));
  mpb_ext_mem mem (.mclk, .e_clock, .address_latch_pulse, .strobe_out_b, .port_b_out, .pc_pin(port_c_in), .pc_drv);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic tick(int n = 1);
    repeat (n) @(posedge mclk);
  endtask
  function automatic bit tally(bit bad);
    samples_checked++;
    return bad;
  endfunction
  task automatic err(string m);
    miscompares++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic reset_dut(logic [1:0] m);
    {boot_select_high, boot_select_low} <= m;
    rst <= 1'b1;
    tick(6);
    rst <= 1'b0;
    tick(4);
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick();
    reg_wr <= 1'b0;
    tick();
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick();
    reg_rd <= 1'b0;
    tick();
    if (tally(reg_rdata !== e)) err("register read");
  endtask
  task automatic bus(logic [15:0] a, logic [7:0] d, logic w, logic f);
    int n;
    logic [8:0] ex;
    cpu_bus_addr <= a;
    cpu_bus_wdata <= d;
    cpu_bus_wr <= w;
    cpu_opfetch <= f;
    n = 0;
    do begin
      tick();
      n++;
      ex = cpu_cycle_start ? {a[15:8], !w} : {pa[15:8], !pw};
      if (tally({port_b_out, strobe_out_b} !== ex)) err("bus high address or direction");
    end while (!cpu_cycle_start && n < 8);
    if (n == 8) err("bus cycle start missing");
    pa = a;
    pw = w;
  endtask
  task automatic t_modes();
    for (int i = 0; i < 4; i++) begin
      reset_dut(i[1:0]);
      if (tally(op_mode !== i[1:0])) err("latched mode");
    end
    $display("modes done");
  endtask
  task automatic t_expanded();
    bus(16'h0000, 8'h00, 1'b0, 1'b0);
    bus(16'h1234, 8'ha5, 1'b1, 1'b0);
    bus(16'h1235, 8'h5a, 1'b1, 1'b0);
    bus(16'h1234, 8'h00, 1'b0, 1'b1);
    bus(16'h1235, 8'h00, 1'b0, 1'b0);
    tick(2);
    if (tally(cpu_bus_rdata !== 8'ha5 || cpu_bus_done !== 1'b1)) err("first read data");
    bus(16'h0000, 8'h00, 1'b0, 1'b0);
    tick(2);
    if (tally(cpu_bus_rdata !== 8'h5a || cpu_bus_done !== 1'b1)) err("second read data");
    $display("expanded bus done");
  endtask
  task automatic t_single();
    int lows = 0;
    reset_dut(`MPB_MODE_SINGLE);
    if (tally(input_capture !== 3'b101)) err("capture inputs");
    wr(`MPB_A_PA_DIR, 8'hff);
    wr(`MPB_A_PA_DATA, 8'h5a);
    tick();
    if (tally(port_a_out !== 8'h5a)) err("port A output");
    wr(`MPB_A_CTRL, 8'h02);
    wr(`MPB_A_PB_DATA, 8'h3c);
    for (int i = 0; i < 8; i++) begin
      tick();
      lows += !strobe_out_b;
    end
    if (tally(lows != 4 || port_b_out !== 8'h3c)) err("port B write strobe");
    pb_ovr <= 1'b1;
    tick(4);
    rd(`MPB_A_PB_DATA, 8'hc3);
    pc_ext <= 8'h96;
    tick(3);
    strobe_in_a <= 1'b0;
    tick(5);
    rd(`MPB_A_PC_LATCH, 8'h96);
    rd(`MPB_A_STATUS, 8'h16);
    rd(`MPB_A_STATUS, 8'h06);
    rd(4'hf, 8'h00);
    strobe_in_a <= 1'b1;
    $display("single-chip ports done");
  endtask
  task automatic t_clock_stop();
    int rises = 0;
    logic e0;
    e0 = e_clock;
    for (int i = 0; i < 16; i++) begin
      tick();
      rises += e_clock && !e0;
      e0 = e_clock;
    end
    if (tally(rises != 4)) err("bus clock rate");
    stop_mode <= 1'b1;
    tick(3);
    e0 = e_clock;
    tick(6);
    if (tally(e_clock !== e0)) err("bus clock in stop");
    stop_mode <= 1'b0;
    tick(8);
    $display("clock and stop done");
  endtask
  task automatic t_irq();
    nonmaskable_interrupt_in <= 1'b0;
    tick(5);
    if (tally(nonmaskable_interrupt_in_request !== 1'b0)) err("masked nonmaskable");
    xmask_clear <= 1'b1;
    tick();
    xmask_clear <= 1'b0;
    tick(5);
    if (tally(nonmaskable_interrupt_in_request !== 1'b1)) err("nonmaskable after clear");
    nonmaskable_interrupt_in <= 1'b1;
    irq_n <= 1'b0;
    tick(5);
    if (tally(irq_request !== 1'b1)) err("level request");
    wr(`MPB_A_CTRL, 8'h01);
    irq_ack <= 1'b1;
    tick();
    irq_ack <= 1'b0;
    tick(4);
    if (tally(irq_request !== 1'b0)) err("edge request after ack");
    reset_dut(`MPB_MODE_SINGLE);
    tick(3);
    if (tally(irq_request !== 1'b1)) err("level after reset");
    irq_n <= 1'b1;
    $display("interrupts done");
  endtask
  task automatic t_fail_drive();
    for (int i = 0; i < 2; i++) begin
      {clock_monitor_fail, watchdog_fail} <= i ? 2'b10 : 2'b01;
      tick();
      {clock_monitor_fail, watchdog_fail} <= 2'b00;
      tick(4);
      if (tally(reset_n_oe !== 1'b1)) err("reset pin not pulled");
      tick(40);
      if (tally(reset_n_oe !== 1'b0 || core_reset !== 1'b0)) err("reset pin not released");
    end
    $display("failure reset done");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    tick(10000);
    miscompares++;
    end_of_test();
  end
  initial begin
    reset_dut(`MPB_MODE_EXP);
    t_modes();
    t_expanded();
    t_single();
    t_clock_stop();
    t_irq();
    t_fail_drive();
    end_of_test();
  end
endmodule
`default_nettype wire
